/* caf_checker.sv */
// link and filter checker beside the interface joining both ends
`timescale 1ns/100ps
module caf_checker
  import caf_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register link
  input wire logic req,
  input wire logic we,
  input wire logic [6:0] addr,
  input wire logic [31:0] wdata,
  input wire logic ack,
  input wire logic [31:0] rdata,
  // filter result
  input wire logic rx_valid,
  input wire logic hit_valid,
  input wire logic [3:0] hit_obj
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // read answer: addr is still held in the ack cycle
  wire rd_ack = ack && !we;
  // ----------------------------------------
  // link handshake
  // ----------------------------------------
  sequence s_take;
    req && !ack;
  endsequence
  sequence s_done;
    ##1 ack ##1 !req;
  endsequence
  property p_link_walk;
    s_take |-> s_done;
  endproperty
  a_link_walk: assert property (p_link_walk) else $error("link access not closed in two cycles");
  property p_ack_pulse;
    ack |=> !ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_req_hold;
    s_take |=> $stable(addr) && $stable(we) && $stable(wdata);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed before ack");
  // ----------------------------------------
  // reserved fields read back as zero
  // ----------------------------------------
  property p_sgm_rsv;
    rd_ack && addr == CAF_A_SGM |-> rdata[31:16] == 16'h0 && rdata[12:8] == 5'h0;
  endproperty
  a_sgm_rsv: assert property (p_sgm_rsv) else $error("standard mask reserved bits set");
  property p_egm_rsv;
    rd_ack && addr == CAF_A_EGM |-> rdata[26:24] == 3'h0;
  endproperty
  a_egm_rsv: assert property (p_egm_rsv) else $error("extended mask reserved bits set");
  property p_cfg_rsv;
    rd_ack && addr[6:4] == CAF_G_CFG |-> rdata[31:8] == 24'h0 && rdata[1:0] == 2'h0;
  endproperty
  a_cfg_rsv: assert property (p_cfg_rsv) else $error("config reserved bits set");
  property p_id_rsv;
    rd_ack && addr[6:4] == CAF_G_ID |-> rdata[26:24] == 3'h0;
  endproperty
  a_id_rsv: assert property (p_id_rsv) else $error("identifier reserved bits set");
  // ----------------------------------------
  // one result per frame, held between frames
  // ----------------------------------------
  property p_hit_pair;
    1'b1 |=> hit_valid == $past(rx_valid);
  endproperty
  a_hit_pair: assert property (p_hit_pair) else $error("result pulse not one per frame");
  property p_hit_hold;
    !hit_valid |-> $stable(hit_obj);
  endproperty
  a_hit_hold: assert property (p_hit_hold) else $error("result object changed without a frame");
endmodule : caf_checker

/* caf_device.sv */
// acceptance filter with message object configuration and identifier store
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
module caf_device
  import caf_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register link
  caf_link_if.dev link,
  // incoming frame, same clock domain
  input wire logic rx_valid,
  input wire logic [28:0] rx_id,
  input wire logic rx_ext,
  input wire logic [3:0] rx_dlc,
  // acceptance result, one per frame
  output logic hit_valid,
  output logic [3:0] hit_obj,
  // timing setting sanity
  output logic timing_ok
);

  typedef struct packed {
    logic [15:0] sgm;
    logic [31:0] egm;
    logic [31:0] m15;
    logic [CAF_NUM_OBJ-1:0] val;
    logic [9:0] tim;
    logic [CAF_NUM_OBJ-1:0][7:0] cfg;
    logic [CAF_NUM_OBJ-1:0][31:0] id;
    logic ack;
    logic [31:0] rdata;
    logic hit_v;
    logic [3:0] hit_o;
    logic tok;
  } caf_dev_st_t;

  caf_dev_st_t s_q;
  caf_dev_st_t s_d;

  //----------------------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------------------

  // one object against the frame under a given effective mask
  function automatic logic obj_hit(input logic v, input logic [7:0] c, input logic [31:0] idr,
                                   input logic [28:0] m, input logic [28:0] fid, input logic fext);
    logic ok;
    ok = v;
    ok = ok && !c[CAF_CFG_DIR];
    ok = ok && (c[CAF_CFG_LONG] == fext);
    ok = ok && (((caf_unpack(idr) ^ fid) & m) == 29'h0);
    return ok;
  endfunction : obj_hit

  //----------------------------------------------------------------------------
  // bit timing view
  //----------------------------------------------------------------------------

  logic [4:0] t1_eff;
  logic [4:0] t2_eff;
  logic [4:0] jump_eff;
  logic [4:0] triple_add;
  logic tim_good;

  // hardware adds one quantum to each field, two more to segment one in three-sample mode
  always_comb begin
    triple_add = s_q.tim[CAF_TIM_TRIPLE] ? CAF_QU_3S : 5'h00;
    t1_eff = {1'b0, s_q.tim[CAF_TIM_T1 +: 4]} + CAF_QU_ADD + triple_add;
    t2_eff = {2'b00, s_q.tim[CAF_TIM_T2 +: 3]} + CAF_QU_ADD;
    jump_eff = {3'b000, s_q.tim[CAF_TIM_JUMP +: 2]} + CAF_QU_ADD;
    // limits are software's duty; flagged here so a bad setting is visible
    tim_good = (t1_eff >= CAF_QU_MIN_T1)
               && (t1_eff >= jump_eff + CAF_QU_PROP + triple_add)
               && (t2_eff >= CAF_QU_MIN_T2) && (t2_eff >= jump_eff);
  end

  //----------------------------------------------------------------------------
  // read decode
  //----------------------------------------------------------------------------

  logic [3:0] oi;
  logic [3:0] ox;
  logic [31:0] rd_word;

  assign oi = link.addr[3:0];
  assign ox = oi - 4'h1;

  // unmapped addresses and object index 0 read as zero
  always_comb begin
    rd_word = 32'h0;
    case (link.addr[6:4])
      CAF_G_MISC: begin
        case (link.addr)
          CAF_A_SGM: rd_word = {16'h0, s_q.sgm};
          CAF_A_EGM: rd_word = s_q.egm;
          CAF_A_M15: rd_word = s_q.m15;
          CAF_A_VAL: rd_word = {17'h0, s_q.val};
          CAF_A_TIM: rd_word = {22'h0, s_q.tim};
          CAF_A_TEFF: rd_word = {15'h0, tim_good, 3'h0, t2_eff, 3'h0, t1_eff};
          default: rd_word = 32'h0;
        endcase
      end
      CAF_G_CFG: begin
        if (oi != 4'h0) begin
          rd_word = {24'h0, s_q.cfg[ox]};
        end
      end
      CAF_G_ID: begin
        if (oi != 4'h0) begin
          rd_word = s_q.id[ox];
        end
      end
      default: rd_word = 32'h0;
    endcase
  end

  //----------------------------------------------------------------------------
  // next state
  //----------------------------------------------------------------------------

  logic [28:0] gmask;
  logic [28:0] fid;
  logic found;
  logic [3:0] kh;

  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.hit_v = 1'b0;
    s_d.tok = tim_good;
    found = 1'b0;
    kh = 4'h0;
    // standard frames carry their 11 bits in identifier bits 28..18
    fid = rx_ext ? rx_id : {rx_id[28:18], 18'h00000};
    gmask = rx_ext ? caf_unpack(s_q.egm) : caf_std_mask(s_q.sgm);

    // link access, answered one cycle after req is seen and not re-answered
    if (link.req && !s_q.ack) begin
      s_d.ack = 1'b1;
      s_d.rdata = rd_word;
      if (link.we) begin
        case (link.addr[6:4])
          CAF_G_MISC: begin
            case (link.addr)
              CAF_A_SGM: s_d.sgm = link.wdata[15:0] & CAF_SGM_WMASK;
              CAF_A_EGM: s_d.egm = link.wdata & CAF_EGM_WMASK;
              // reserved bits keep whatever they held
              CAF_A_M15: s_d.m15 = (link.wdata & ~CAF_M15_RSV) | (s_q.m15 & CAF_M15_RSV);
              CAF_A_VAL: s_d.val = link.wdata[CAF_NUM_OBJ-1:0];
              CAF_A_TIM: s_d.tim = link.wdata[9:0];
              default: ;
            endcase
          end
          CAF_G_CFG: begin
            if (oi != 4'h0) begin
              s_d.cfg[ox] = link.wdata[7:0] & CAF_CFG_WMASK;
            end
          end
          CAF_G_ID: begin
            if (oi != 4'h0) begin
              s_d.id[ox] = link.wdata & CAF_ID_WMASK;
            end
          end
          default: ;
        endcase
      end
    end

    // acceptance: objects 1-14 in order, object 15 only when none of them hit
    if (rx_valid) begin
      s_d.hit_v = 1'b1;
      for (int k = 0; k < CAF_NUM_OBJ - 1; k++) begin
        if (!found && obj_hit(s_q.val[k], s_q.cfg[k], s_q.id[k], gmask, fid, rx_ext)) begin
          found = 1'b1;
          kh = 4'(k + 1);
        end
      end
      if (!found && obj_hit(s_q.val[CAF_NUM_OBJ-1], s_q.cfg[CAF_NUM_OBJ-1], s_q.id[CAF_NUM_OBJ-1],
                            gmask & caf_unpack(s_q.m15), fid, rx_ext)) begin
        found = 1'b1;
        kh = 4'(CAF_NUM_OBJ);
      end
      s_d.hit_o = kh;
      // reception's byte count wins over a software write to the same config in this cycle
      if (found) begin
        s_d.cfg[kh - 4'h1][CAF_CFG_BCNT +: 4] = rx_dlc;
      end
    end

    // standard objects never hold extended low bits
    for (int k = 0; k < CAF_NUM_OBJ; k++) begin
      if (!s_d.cfg[k][CAF_CFG_LONG]) begin
        s_d.id[k] = s_d.id[k] & CAF_ID_STD_KEEP;
      end
    end
  end

  //----------------------------------------------------------------------------
  // state register
  //----------------------------------------------------------------------------

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state flops
  assign link.ack = s_q.ack;
  assign link.rdata = s_q.rdata;
  assign hit_valid = s_q.hit_v;
  assign hit_obj = s_q.hit_o;
  assign timing_ok = s_q.tok;

endmodule : caf_device

/* caf_host.sv */
// controller end: AXI4-Lite command registers relayed onto the device link
`timescale 1ns/100ps
module caf_host
  import caf_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address and data
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // device link
  caf_link_if.host link
);

  typedef struct packed {
    logic aw_got;
    logic [3:0] aw_a;
    logic w_got;
    logic [31:0] w_d;
    logic awr;
    logic wr;
    logic arr;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [1:0] rr;
    logic [31:0] rd;
    logic [31:0] wreg;
    logic [31:0] rdreg;
    logic busy;
    logic req;
    logic we;
    logic [6:0] addr;
    logic [31:0] lwd;
  } caf_host_st_t;

  caf_host_st_t s_q;
  caf_host_st_t s_d;

  //----------------------------------------------------------------------------
  // next state
  //----------------------------------------------------------------------------

  always_comb begin
    s_d = s_q;
    // address and data are taken independently, in either order
    if (awvalid && s_q.awr) begin
      s_d.aw_got = 1'b1;
      s_d.aw_a = awaddr;
    end
    if (wvalid && s_q.wr) begin
      s_d.w_got = 1'b1;
      s_d.w_d = wdata;
    end
    if (s_q.bv && bready) begin
      s_d.bv = 1'b0;
    end
    // a completed link access frees the command slot
    if (s_q.req && link.ack) begin
      s_d.req = 1'b0;
      s_d.busy = 1'b0;
      if (!s_q.we) begin
        s_d.rdreg = link.rdata;
      end
    end
    // write performed once both halves are held and the response slot is free
    if (s_q.aw_got && s_q.w_got && !s_q.bv) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bv = 1'b1;
      s_d.br = CAF_RESP_OK;
      case (s_q.aw_a)
        // a command while busy is dropped; software polls status first
        CAF_H_CMD: begin
          if (!s_q.busy) begin
            s_d.req = 1'b1;
            s_d.busy = 1'b1;
            s_d.we = s_q.w_d[CAF_CMD_WE];
            s_d.addr = s_q.w_d[CAF_CMD_ADDR +: 7];
            s_d.lwd = s_q.wreg;
          end
        end
        CAF_H_WDATA: s_d.wreg = s_q.w_d;
        CAF_H_RDATA: ;
        CAF_H_STAT: ;
        default: s_d.br = CAF_RESP_ERR;
      endcase
    end
    // read
    if (s_q.rv && rready) begin
      s_d.rv = 1'b0;
    end
    if (arvalid && s_q.arr) begin
      s_d.rv = 1'b1;
      s_d.rr = CAF_RESP_OK;
      case (araddr)
        CAF_H_CMD: s_d.rd = {17'h0, s_q.addr, 7'h0, s_q.we};
        CAF_H_WDATA: s_d.rd = s_q.wreg;
        CAF_H_RDATA: s_d.rd = s_q.rdreg;
        CAF_H_STAT: s_d.rd = {31'h0, s_q.busy};
        default: begin
          s_d.rd = 32'h0;
          s_d.rr = CAF_RESP_ERR;
        end
      endcase
    end
    // readies registered: low while a half is held or a response waits
    s_d.awr = !s_d.aw_got && !s_d.bv && !s_q.awr;
    s_d.wr = !s_d.w_got && !s_d.bv && !s_q.wr;
    s_d.arr = !s_d.rv && !s_q.arr;
  end

  //----------------------------------------------------------------------------
  // state register
  //----------------------------------------------------------------------------

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign awready = s_q.awr;
  assign wready = s_q.wr;
  assign arready = s_q.arr;
  assign bvalid = s_q.bv;
  assign bresp = s_q.br;
  assign rvalid = s_q.rv;
  assign rresp = s_q.rr;
  assign rdata = s_q.rd;
  assign link.req = s_q.req;
  assign link.we = s_q.we;
  assign link.addr = s_q.addr;
  assign link.wdata = s_q.lwd;

endmodule : caf_host

/* caf_link_if.sv */
// register link between the controller end and the filter device end
`timescale 1ns/100ps
interface caf_link_if;
  logic req;
  logic we;
  logic [6:0] addr;
  logic [31:0] wdata;
  logic ack;
  logic [31:0] rdata;
  modport dev (input req, input we, input addr, input wdata, output ack, output rdata);
  modport host (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface : caf_link_if

/* caf_pkg.sv */
// constants, layouts and helpers shared by both ends of the acceptance filter link
//------------------------------------------------------------------------------
// Overview of operation
// - pre-sample segment at least three quanta, margin-checked
// - post-sample segment at least two quanta, jump width
// - zero mask bit is don't-care, else exact
// - standard mask for 11-bit, extended for 29-bit
// - objects 1-14 first, then object 15
// - standard mask bit layout, bits 12:8 zero
// - extended mask bit layout, bits 26:24 zero
// - mask 0 allows either, 1 requires match
// - object 15 mask ANDed with global mask
// - object 15 mask bits 26:24 left untouched
// - byte count in config bits 7:4, 0-8
// - reception overwrites receive object's byte count
// - config bit 3: 0 receive, 1 transmit
// - config bit 2: identifier type, 1:0 zero
// - standard object forces low 18 identifier bits zero
// - extended object never accepts standard frames
// - extended in bits 28..0, standard 28..18
// - identifier register bit layout
// - invalidate, rewrite identifier, revalidate
// - only valid objects are read or updated
// - segments lengthened by one quantum, three-sample +2
//------------------------------------------------------------------------------
package caf_pkg;
  localparam int CAF_NUM_OBJ = 15;
  localparam int CAF_AW = 7;
  // device register addresses on the link, object x sits at base plus x
  localparam logic [6:0] CAF_A_SGM = 7'h00;
  localparam logic [6:0] CAF_A_EGM = 7'h01;
  localparam logic [6:0] CAF_A_M15 = 7'h02;
  localparam logic [6:0] CAF_A_VAL = 7'h03;
  localparam logic [6:0] CAF_A_TIM = 7'h04;
  localparam logic [6:0] CAF_A_TEFF = 7'h05;
  localparam logic [2:0] CAF_G_MISC = 3'h0;
  localparam logic [2:0] CAF_G_CFG = 3'h1;
  localparam logic [2:0] CAF_G_ID = 3'h2;
  // writable bits and reserved fields
  localparam logic [15:0] CAF_SGM_WMASK = 16'he0ff;
  localparam logic [31:0] CAF_EGM_WMASK = 32'hf8ff_ffff;
  localparam logic [31:0] CAF_M15_RSV = 32'h0700_0000;
  localparam logic [7:0] CAF_CFG_WMASK = 8'hfc;
  localparam logic [31:0] CAF_ID_WMASK = 32'hf8ff_ffff;
  localparam logic [31:0] CAF_ID_STD_KEEP = 32'h0000_e0ff;
  localparam int CAF_CFG_DIR = 3;
  localparam int CAF_CFG_LONG = 2;
  localparam int CAF_CFG_BCNT = 4;
  // bit timing fields and limits in time quanta
  localparam int CAF_TIM_T1 = 0;
  localparam int CAF_TIM_T2 = 4;
  localparam int CAF_TIM_TRIPLE = 7;
  localparam int CAF_TIM_JUMP = 8;
  localparam logic [4:0] CAF_QU_MIN_T1 = 5'h03;
  localparam logic [4:0] CAF_QU_MIN_T2 = 5'h02;
  localparam logic [4:0] CAF_QU_PROP = 5'h01;
  localparam logic [4:0] CAF_QU_3S = 5'h02;
  localparam logic [4:0] CAF_QU_ADD = 5'h01;
  // host register byte offsets
  localparam logic [3:0] CAF_H_CMD = 4'h0;
  localparam logic [3:0] CAF_H_WDATA = 4'h4;
  localparam logic [3:0] CAF_H_RDATA = 4'h8;
  localparam logic [3:0] CAF_H_STAT = 4'hc;
  localparam int CAF_CMD_WE = 0;
  localparam int CAF_CMD_ADDR = 8;
  localparam logic [1:0] CAF_RESP_OK = 2'h0;
  localparam logic [1:0] CAF_RESP_ERR = 2'h2;

  // identifier/mask register word to identifier bits 28..0
  function automatic logic [28:0] caf_unpack(input logic [31:0] r);
    return {r[7:0], r[15:13], r[12:8], r[23:16], r[31:27]};
  endfunction : caf_unpack

  // standard mask covers identifier bits 28..18 only
  function automatic logic [28:0] caf_std_mask(input logic [15:0] r);
    return {r[7:0], r[15:13], 18'h00000};
  endfunction : caf_std_mask
endpackage : caf_pkg

/* can_acceptance_filter_msgobj_cfg_tb_top.sv */
// self-checking bench for the host and device ends of the filter link
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module can_acceptance_filter_msgobj_cfg_tb_top
  import caf_pkg::*;
;
  logic aclk;
  logic aresetn;
  logic [3:0] awaddr, araddr, wstrb, rx_dlc, hit_obj;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic rx_valid, rx_ext, hit_valid, timing_ok;
  logic [28:0] rx_id;
  int n_errors = 0;
  int n_compared = 0;
  int n_ack = 0;
  localparam logic [28:0] X = 29'h0abc_1234;
  caf_link_if lnk();
  caf_host i_caf_host (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .link(lnk));
  caf_device i_caf_device (.aclk, .aresetn, .link(lnk), .rx_valid, .rx_id, .rx_ext, .rx_dlc,
    .hit_valid, .hit_obj, .timing_ok);
  caf_checker i_caf_checker (.aclk, .aresetn, .req(lnk.req), .we(lnk.we), .addr(lnk.addr),
    .wdata(lnk.wdata), .ack(lnk.ack), .rdata(lnk.rdata), .rx_valid, .hit_valid, .hit_obj);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // counting acks avoids missing one that lands during the write response
  always @(posedge aclk) begin
    if (lnk.ack) n_ack <= n_ack + 1;
  end
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 40) begin n_errors++; summarize(); end
    `CHK(bresp, er);
    // a cycle apart, so a following write never re-raises bready in the same step
    @(posedge aclk);
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, input logic [1:0] er);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    d = rdata;
    if (n == 40) begin n_errors++; summarize(); end
    `CHK(rresp, er);
    // a cycle apart, so a following read never re-raises rready in the same step
    @(posedge aclk);
  endtask : axi_rd
  // device access through the command register, closed on the link ack
  task automatic dev_go(input logic [6:0] da, input logic w);
    int n;
    int n0;
    n0 = n_ack;
    axi_wr(CAF_H_CMD, {17'h0, da, 7'h0, w}, CAF_RESP_OK);
    for (n = 0; n < 20 && n_ack == n0; n++) begin
      @(posedge aclk);
      #1;
    end
    if (n == 20) begin n_errors++; summarize(); end
    @(posedge aclk);
  endtask : dev_go
  task automatic dev_wr(input logic [6:0] da, input logic [31:0] d);
    axi_wr(CAF_H_WDATA, d, CAF_RESP_OK);
    dev_go(da, 1'b1);
  endtask : dev_wr
  task automatic dev_rd(input logic [6:0] da, input logic [31:0] x);
    dev_go(da, 1'b0);
    axi_rd(CAF_H_RDATA, rd, CAF_RESP_OK);
    `CHK(rd, x);
  endtask : dev_rd
  // identifier bits into the register word layout
  function automatic logic [31:0] pk(input logic [28:0] i);
    return {i[4:0], 3'h0, i[12:5], i[20:18], i[17:13], i[28:21]};
  endfunction : pk
  task automatic frame(input logic [28:0] id, input logic ext, input logic [3:0] k);
    rx_id <= id;
    rx_ext <= ext;
    rx_dlc <= 4'h6;
    rx_valid <= 1'b1;
    @(posedge aclk);
    rx_valid <= 1'b0;
    #1;
    `CHK(hit_valid, 1'b1);
    `CHK(hit_obj, k);
    @(posedge aclk);
  endtask : frame
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_host();
    axi_rd(CAF_H_WDATA, rd, CAF_RESP_OK);
    `CHK(rd, 32'h0);
    axi_wr(CAF_H_WDATA, 32'ha5c3_0f96, CAF_RESP_OK);
    axi_rd(CAF_H_WDATA, rd, CAF_RESP_OK);
    `CHK(rd, 32'ha5c3_0f96);
    axi_wr(4'h2, 32'h1, CAF_RESP_ERR);
    axi_rd(4'h2, rd, CAF_RESP_ERR);
    axi_rd(CAF_H_STAT, rd, CAF_RESP_OK);
    `CHK(rd, 32'h0);
    $display("host registers done");
  endtask : t_host
  task automatic t_regs();
    dev_wr(CAF_A_SGM, 32'hffff_ffff);
    dev_rd(CAF_A_SGM, 32'h0000_e0ff);
    dev_wr(CAF_A_EGM, 32'hffff_ffff);
    dev_rd(CAF_A_EGM, 32'hf8ff_ffff);
    dev_wr(7'h11, 32'hff);
    dev_rd(7'h11, 32'hfc);
    dev_wr(7'h21, 32'hffff_ffff);
    dev_rd(7'h21, 32'hf8ff_ffff);
    dev_wr(7'h11, 32'h0);
    dev_rd(7'h21, 32'h0000_e0ff);
    dev_wr(CAF_A_TIM, 32'h92);
    dev_rd(CAF_A_TEFF, 32'h0001_0205);
    `CHK(timing_ok, 1'b1);
    // segment one too short for jump width plus allowance, in three-sample mode
    dev_wr(CAF_A_TIM, 32'h2b2);
    dev_rd(CAF_A_TEFF, 32'h0000_0405);
    `CHK(timing_ok, 1'b0);
    // segment two shorter than the jump width, segment one ample
    dev_wr(CAF_A_TIM, 32'h21f);
    dev_rd(CAF_A_TEFF, 32'h0000_0210);
    `CHK(timing_ok, 1'b0);
    // command register keeps the last link access: read of address 0x05
    axi_rd(CAF_H_CMD, rd, CAF_RESP_OK);
    `CHK(rd, 32'h0000_0500);
    $display("device registers done");
  endtask : t_regs
  task automatic t_filter();
    dev_wr(7'h12, 32'h04);
    dev_wr(7'h22, pk(X));
    dev_wr(7'h13, 32'h00);
    dev_wr(7'h23, pk({11'h5a3, 18'h0})); // standard identifier in the top 11 bits only
    dev_wr(7'h14, 32'h0c);
    dev_wr(7'h24, pk(X ^ 29'h4));
    dev_wr(7'h1f, 32'h04);
    dev_wr(7'h2f, pk(X));
    dev_wr(CAF_A_M15, 32'he8ff_ffff); // reserved bits kept as read
    dev_wr(CAF_A_VAL, 32'h400e); // objects validated after the rewrite
    frame(X, 1'b1, 4'h2);
    frame({11'h5a3, 18'h3ffff}, 1'b0, 4'h3);
    frame(X, 1'b0, 4'h0);
    frame(X ^ 29'h4, 1'b1, 4'h0);
    frame(X ^ 29'h2, 1'b1, 4'hf);
    dev_wr(CAF_A_EGM, 32'hf7ff_ffff);
    frame(X ^ 29'h1, 1'b1, 4'h2);
    dev_wr(CAF_A_VAL, 32'h400c);
    dev_wr(CAF_A_EGM, 32'hefff_ffff);
    dev_wr(CAF_A_M15, 32'hf8ff_ffff);
    frame(X ^ 29'h2, 1'b1, 4'hf);
    dev_rd(7'h12, 32'h64);
    dev_rd(7'h14, 32'h0c);
    $display("filter done");
  endtask : t_filter
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, rx_valid, rx_ext} = 7'h0;
    {awaddr, araddr, rx_dlc} = 12'h0;
    wdata = 32'h0;
    rx_id = 29'h0;
    wstrb = 4'hf;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_host();
    t_regs();
    t_filter();
    summarize();
  end
endmodule : can_acceptance_filter_msgobj_cfg_tb_top
